// [verilog/nfi_map.svh]
// Register offsets, bit positions, codes and reset values of the FIFO irq block.
`ifndef NFI_MAP_SVH
`define NFI_MAP_SVH

// ----------------------------------------------------------------
// Bus and register map
// ----------------------------------------------------------------
`define NFI_ADDR_W 14
`define NFI_OFF_SOURCE 14'h0000
`define NFI_OFF_MASK 14'h0004
`define NFI_OFF_CLEAR 14'h0008
`define NFI_MASK_RESET 32'hFFFFFFFF
`define NFI_RAW_W 9
`define NFI_RAW_RESET 9'h000
`define NFI_RAW_PAD 23'h000000

// ----------------------------------------------------------------
// Source bit positions
// ----------------------------------------------------------------
`define NFI_RECV_EXT_ERROR_FLAG 8
`define NFI_BUS_POP_ERROR_FLAG 7
`define NFI_BUS_PUSH_ERROR_FLAG 6
`define NFI_RECV_FIFO_FULL_FLAG 5
`define NFI_RECV_FIFO_THRESHOLD_FLAG 4
`define NFI_RECV_FIFO_HAS_DATA_FLAG 3
`define NFI_XMIT_FIFO_HAS_SPACE_FLAG 2
`define NFI_XMIT_FIFO_THRESHOLD_FLAG 1
`define NFI_XMIT_FIFO_DRAINED_FLAG 0

// ----------------------------------------------------------------
// Access width codes and byte pointer
// ----------------------------------------------------------------
`define NFI_SIZE_BYTE 2'h0
`define NFI_SIZE_HALF 2'h1
`define NFI_SIZE_WORD 2'h2
`define NFI_BYTE_PTR_ZERO 2'h0

`endif

// [verilog/nfi_pkg.sv]
// Types shared by the FIFO interrupt source and mask logic.
`default_nettype none
`include "nfi_map.svh"
package nfi_pkg;

	// ----------------------------------------------------------------
	// Whole state of the block
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [`NFI_RAW_W-1:0] raw;
		logic [31:0] mask;
		logic prev_recv_full;
		logic prev_recv_empty;
		logic prev_xmit_full;
		logic prev_xmit_empty;
		logic [1:0] last_ext_push_size;
		logic [1:0] last_bus_pop_size;
		logic [1:0] last_bus_push_size;
		logic [31:0] prdata;
		logic pready;
		logic irq;
	} nfi_state_type;

endpackage
`default_nettype wire

// [verilog/nfi_irq_logic.sv]
// Interrupt source, mask and clear registers for the NAND FIFO events.
`timescale 1ns/100ps
`default_nettype none
`include "nfi_map.svh"

module nfi_irq_logic
	import nfi_pkg::*;
#(
	parameter int LEVEL_W = 13
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`NFI_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic nand_irq,
	input wire logic recv_fifo_full,
	input wire logic recv_fifo_empty,
	input wire logic [LEVEL_W-1:0] recv_fifo_level,
	input wire logic [LEVEL_W-1:0] recv_half_level,
	input wire logic [1:0] recv_byte_ptr,
	input wire logic xmit_fifo_full,
	input wire logic xmit_fifo_empty,
	input wire logic [LEVEL_W-1:0] xmit_fifo_space,
	input wire logic [LEVEL_W-1:0] xmit_half_level,
	input wire logic [1:0] xmit_byte_ptr,
	input wire logic nand_recv_push,
	input wire logic [1:0] nand_recv_push_size,
	input wire logic bus_recv_pop,
	input wire logic [1:0] bus_recv_pop_size,
	input wire logic bus_xmit_push,
	input wire logic [1:0] bus_xmit_push_size
);

	// ----------------------------------------------------------------
	// State and helpers
	// ----------------------------------------------------------------
	nfi_state_type state;
	nfi_state_type next_state;
	logic [`NFI_RAW_W-1:0] set_bits;
	logic [`NFI_RAW_W-1:0] clear_bits;
	logic bus_write;

	// A width change only hurts when a partial word is already in flight.
	function automatic logic misaligned(input logic [1:0] size,
		input logic [1:0] last, input logic [1:0] ptr);
		return (size != last) && (ptr != `NFI_BYTE_PTR_ZERO);
	endfunction

	assign bus_write = psel && penable && pwrite && state.pready;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		set_bits = `NFI_RAW_RESET;
		clear_bits = `NFI_RAW_RESET;
		set_bits[`NFI_RECV_EXT_ERROR_FLAG] = nand_recv_push && (recv_fifo_full
			|| misaligned(nand_recv_push_size, state.last_ext_push_size,
			recv_byte_ptr));
		set_bits[`NFI_BUS_POP_ERROR_FLAG] = bus_recv_pop && (recv_fifo_empty
			|| misaligned(bus_recv_pop_size, state.last_bus_pop_size,
			recv_byte_ptr));
		set_bits[`NFI_BUS_PUSH_ERROR_FLAG] = bus_xmit_push && (xmit_fifo_full
			|| misaligned(bus_xmit_push_size, state.last_bus_push_size,
			xmit_byte_ptr));
		set_bits[`NFI_RECV_FIFO_FULL_FLAG] =
			recv_fifo_full && !state.prev_recv_full;
		set_bits[`NFI_RECV_FIFO_THRESHOLD_FLAG] =
			recv_fifo_level > recv_half_level;
		set_bits[`NFI_RECV_FIFO_HAS_DATA_FLAG] =
			!recv_fifo_empty && state.prev_recv_empty;
		set_bits[`NFI_XMIT_FIFO_HAS_SPACE_FLAG] =
			!xmit_fifo_full && state.prev_xmit_full;
		set_bits[`NFI_XMIT_FIFO_THRESHOLD_FLAG] =
			xmit_fifo_space > xmit_half_level;
		set_bits[`NFI_XMIT_FIFO_DRAINED_FLAG] =
			xmit_fifo_empty && !state.prev_xmit_empty;
		if (bus_write && paddr == `NFI_OFF_CLEAR) begin
			clear_bits = pwdata[`NFI_RAW_W-1:0];
		end
		if (bus_write && paddr == `NFI_OFF_MASK) begin
			next_state.mask = pwdata;
		end
		// A new event in the clearing cycle wins so it is never lost.
		next_state.raw = (state.raw & ~clear_bits) | set_bits;
		next_state.prev_recv_full = recv_fifo_full;
		next_state.prev_recv_empty = recv_fifo_empty;
		next_state.prev_xmit_full = xmit_fifo_full;
		next_state.prev_xmit_empty = xmit_fifo_empty;
		if (nand_recv_push) begin
			next_state.last_ext_push_size = nand_recv_push_size;
		end
		if (bus_recv_pop) begin
			next_state.last_bus_pop_size = bus_recv_pop_size;
		end
		if (bus_xmit_push) begin
			next_state.last_bus_push_size = bus_xmit_push_size;
		end
		// Read data is captured in the setup phase; zero wait states.
		next_state.pready = psel && !penable;
		next_state.prdata = 32'h00000000;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				`NFI_OFF_SOURCE: begin
					next_state.prdata = {`NFI_RAW_PAD, state.raw};
				end
				`NFI_OFF_MASK: begin
					next_state.prdata = state.mask;
				end
				default: begin
					next_state.prdata = 32'h00000000;
				end
			endcase
		end
		next_state.irq = |(next_state.raw &
			~next_state.mask[`NFI_RAW_W-1:0]);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state.raw <= `NFI_RAW_RESET;
			state.mask <= `NFI_MASK_RESET;
			state.prev_recv_full <= 1'b0;
			state.prev_recv_empty <= 1'b1;
			state.prev_xmit_full <= 1'b0;
			state.prev_xmit_empty <= 1'b1;
			state.last_ext_push_size <= `NFI_SIZE_WORD;
			state.last_bus_pop_size <= `NFI_SIZE_WORD;
			state.last_bus_push_size <= `NFI_SIZE_WORD;
			state.prdata <= 32'h00000000;
			state.pready <= 1'b0;
			state.irq <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign prdata = state.prdata;
	assign pready = state.pready;
	assign nand_irq = state.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_byte_push;
		bus_xmit_push && bus_xmit_push_size == `NFI_SIZE_BYTE;
	endsequence

	sequence s_word_push_off;
		bus_xmit_push && bus_xmit_push_size == `NFI_SIZE_WORD &&
			xmit_byte_ptr != `NFI_BYTE_PTR_ZERO;
	endsequence

	a_ext_push_err: assert property (
		nand_recv_push && recv_fifo_full |=>
			state.raw[`NFI_RECV_EXT_ERROR_FLAG])
		else $error("receive push into full FIFO not flagged");
	a_pop_underrun: assert property (
		bus_recv_pop && recv_fifo_empty |=>
			state.raw[`NFI_BUS_POP_ERROR_FLAG])
		else $error("bus pop underrun not flagged");
	a_push_overrun: assert property (
		bus_xmit_push && xmit_fifo_full |=>
			state.raw[`NFI_BUS_PUSH_ERROR_FLAG])
		else $error("bus push overrun not flagged");
	a_width_change_push: assert property (
		s_byte_push ##1 s_word_push_off |=>
			state.raw[`NFI_BUS_PUSH_ERROR_FLAG])
		else $error("misaligned word push not flagged");
	a_recv_full_edge: assert property (
		!recv_fifo_full ##1 recv_fifo_full |=>
			state.raw[`NFI_RECV_FIFO_FULL_FLAG])
		else $error("receive full edge not flagged");
	a_recv_threshold: assert property (
		recv_fifo_level > recv_half_level |=>
			state.raw[`NFI_RECV_FIFO_THRESHOLD_FLAG])
		else $error("receive threshold not flagged");
	a_recv_has_data: assert property (
		recv_fifo_empty ##1 !recv_fifo_empty |=>
			state.raw[`NFI_RECV_FIFO_HAS_DATA_FLAG])
		else $error("receive data arrival not flagged");
	a_xmit_space: assert property (
		xmit_fifo_full ##1 !xmit_fifo_full |=>
			state.raw[`NFI_XMIT_FIFO_HAS_SPACE_FLAG])
		else $error("transmit space not flagged");
	a_xmit_threshold: assert property (
		xmit_fifo_space > xmit_half_level |=>
			state.raw[`NFI_XMIT_FIFO_THRESHOLD_FLAG])
		else $error("transmit threshold not flagged");
	a_xmit_drained: assert property (
		!xmit_fifo_empty ##1 xmit_fifo_empty |=>
			state.raw[`NFI_XMIT_FIFO_DRAINED_FLAG])
		else $error("transmit empty edge not flagged");
	a_mask_blocks_irq: assert property (
		&state.mask[`NFI_RAW_W-1:0] |-> !nand_irq)
		else $error("interrupt raised with all sources masked");
	a_mask_write_kept: assert property (
		bus_write && paddr == `NFI_OFF_MASK |=> state.mask == $past(pwdata))
		else $error("mask write not stored as written");
	a_source_readback: assert property (
		psel && !penable && !pwrite && paddr == `NFI_OFF_SOURCE |=>
			pready && prdata == {`NFI_RAW_PAD, $past(state.raw)})
		else $error("source read does not return raw flags");
	a_flags_sticky: assert property (
		!(bus_write && paddr == `NFI_OFF_CLEAR) |=>
			(state.raw & $past(state.raw)) == $past(state.raw))
		else $error("raw flag dropped without a clear write");

endmodule
`default_nettype wire

// [sim/nfi_irq_logic_tb_top.sv]
// Self-checking testbench for the FIFO interrupt source and mask logic.
`timescale 1ns/100ps
`default_nettype none
`include "nfi_map.svh"

module nfi_irq_logic_tb_top import nfi_pkg::*;;
	logic ref_clk, srst, psel, penable, pwrite, pready, nand_irq;
	logic [`NFI_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic recv_fifo_full, recv_fifo_empty, xmit_fifo_full, xmit_fifo_empty;
	logic [12:0] recv_fifo_level, recv_half_level;
	logic [12:0] xmit_fifo_space, xmit_half_level;
	logic [1:0] recv_byte_ptr, xmit_byte_ptr;
	logic [1:0] nand_recv_push_size, bus_recv_pop_size, bus_xmit_push_size;
	logic nand_recv_push, bus_recv_pop, bus_xmit_push;
	int fail_count, total_checks;

	nfi_irq_logic #(.LEVEL_W(13)) nfi_irq_logic_i (.ref_clk(ref_clk),
		.srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.nand_irq(nand_irq), .recv_fifo_full(recv_fifo_full),
		.recv_fifo_empty(recv_fifo_empty), .recv_fifo_level(recv_fifo_level),
		.recv_half_level(recv_half_level), .recv_byte_ptr(recv_byte_ptr),
		.xmit_fifo_full(xmit_fifo_full), .xmit_fifo_empty(xmit_fifo_empty),
		.xmit_fifo_space(xmit_fifo_space), .xmit_half_level(xmit_half_level),
		.xmit_byte_ptr(xmit_byte_ptr), .nand_recv_push(nand_recv_push),
		.nand_recv_push_size(nand_recv_push_size), .bus_recv_pop(bus_recv_pop),
		.bus_recv_pop_size(bus_recv_pop_size), .bus_xmit_push(bus_xmit_push),
		.bus_xmit_push_size(bus_xmit_push_size));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Zero wait states, so ready must already stand when enable rises.
	task automatic apb(input logic wr, input logic [`NFI_ADDR_W-1:0] a,
		input logic [31:0] d);
		@(negedge ref_clk);
		psel = 1'b1;
		penable = 1'b0;
		pwrite = wr;
		paddr = a;
		pwdata = d;
		@(negedge ref_clk);
		penable = 1'b1;
		chk("pready", {31'h0, pready}, 32'h1);
		rd_data = prdata;
		@(negedge ref_clk);
		psel = 1'b0;
		penable = 1'b0;
	endtask

	task automatic src_is(input logic [31:0] exp);
		apb(1'b0, `NFI_OFF_SOURCE, 32'h0);
		chk("source", rd_data, exp);
	endtask

	task automatic pulse(input int which, input logic [1:0] sz);
		@(negedge ref_clk);
		nand_recv_push = (which == 0);
		bus_recv_pop = (which == 1);
		bus_xmit_push = (which == 2);
		nand_recv_push_size = sz;
		bus_recv_pop_size = sz;
		bus_xmit_push_size = sz;
		@(negedge ref_clk);
		nand_recv_push = 1'b0;
		bus_recv_pop = 1'b0;
		bus_xmit_push = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		src_is(32'h0);
		apb(1'b0, `NFI_OFF_MASK, 32'h0);
		chk("mask", rd_data, 32'hFFFFFFFF);
		chk("irq", {31'h0, nand_irq}, 32'h0);
		apb(1'b0, `NFI_OFF_CLEAR, 32'h0);
		chk("clear read", rd_data, 32'h0);
		apb(1'b0, 14'h000C, 32'h0);
		chk("unmapped", rd_data, 32'h0);
		$display("test reset done");
	endtask

	task automatic test_edges();
		recv_fifo_empty = 1'b0;
		src_is(32'h008);
		recv_fifo_full = 1'b1;
		src_is(32'h028);
		xmit_fifo_full = 1'b1;
		@(negedge ref_clk);
		xmit_fifo_full = 1'b0;
		src_is(32'h02C);
		xmit_fifo_empty = 1'b0;
		@(negedge ref_clk);
		xmit_fifo_empty = 1'b1;
		src_is(32'h02D);
		apb(1'b1, `NFI_OFF_CLEAR, 32'h0);
		src_is(32'h02D);
		apb(1'b1, `NFI_OFF_CLEAR, 32'h00D);
		src_is(32'h020);
		recv_fifo_full = 1'b0;
		recv_fifo_empty = 1'b1;
		apb(1'b1, `NFI_OFF_CLEAR, 32'h1FF);
		src_is(32'h0);
		$display("test edges done");
	endtask

	task automatic test_levels();
		recv_fifo_level = 13'h0008;
		src_is(32'h0);
		recv_fifo_level = 13'h0009;
		src_is(32'h010);
		apb(1'b1, `NFI_OFF_CLEAR, 32'h010);
		src_is(32'h010);
		recv_fifo_level = 13'h0000;
		apb(1'b1, `NFI_OFF_CLEAR, 32'h010);
		xmit_fifo_space = 13'h0009;
		src_is(32'h002);
		xmit_fifo_space = 13'h0008;
		apb(1'b1, `NFI_OFF_CLEAR, 32'h002);
		src_is(32'h0);
		$display("test levels done");
	endtask

	task automatic test_errors();
		recv_fifo_full = 1'b1;
		pulse(0, `NFI_SIZE_WORD);
		src_is(32'h120);
		recv_fifo_full = 1'b0;
		pulse(1, `NFI_SIZE_WORD);
		src_is(32'h1A0);
		xmit_fifo_full = 1'b1;
		pulse(2, `NFI_SIZE_WORD);
		xmit_fifo_full = 1'b0;
		src_is(32'h1E4);
		recv_fifo_empty = 1'b0;
		apb(1'b1, `NFI_OFF_CLEAR, 32'h1FF);
		pulse(0, `NFI_SIZE_BYTE);
		recv_byte_ptr = 2'h1;
		pulse(0, `NFI_SIZE_BYTE);
		src_is(32'h0);
		pulse(0, `NFI_SIZE_WORD);
		src_is(32'h100);
		recv_byte_ptr = 2'h2;
		pulse(1, `NFI_SIZE_HALF);
		src_is(32'h180);
		xmit_byte_ptr = 2'h3;
		pulse(2, `NFI_SIZE_BYTE);
		src_is(32'h1C0);
		$display("test errors done");
	endtask

	// Raw holds bits 8..6 here; one source at a time is let through.
	task automatic test_mask();
		for (int b = 0; b < 9; b++) begin
			apb(1'b1, `NFI_OFF_MASK, ~(32'h1 << b));
			apb(1'b0, `NFI_OFF_MASK, 32'h0);
			chk("mask", rd_data, ~(32'h1 << b));
			chk("irq", {31'h0, nand_irq}, (b >= 6) ? 32'h1 : 32'h0);
		end
		apb(1'b1, `NFI_OFF_MASK, 32'hFFFFFFFF);
		@(negedge ref_clk);
		chk("irq", {31'h0, nand_irq}, 32'h0);
		apb(1'b1, `NFI_OFF_MASK, 32'h0);
		apb(1'b1, `NFI_OFF_CLEAR, 32'h1C0);
		@(negedge ref_clk);
		chk("irq", {31'h0, nand_irq}, 32'h0);
		$display("test mask done");
	endtask

	// Back-to-back byte then word push with a partial word in flight,
	// then a reset in mid-run with the FIFO status back at idle.
	task automatic test_burst();
		@(negedge ref_clk);
		bus_xmit_push = 1'b1;
		bus_xmit_push_size = `NFI_SIZE_BYTE;
		@(negedge ref_clk);
		bus_xmit_push_size = `NFI_SIZE_WORD;
		@(negedge ref_clk);
		bus_xmit_push = 1'b0;
		src_is(32'h040);
		chk("irq", {31'h0, nand_irq}, 32'h1);
		srst = 1'b1;
		{recv_fifo_empty, recv_byte_ptr, xmit_byte_ptr} = 5'h10;
		repeat (2) @(negedge ref_clk);
		srst = 1'b0;
		src_is(32'h0);
		apb(1'b0, `NFI_OFF_MASK, 32'h0);
		chk("mask", rd_data, 32'hFFFFFFFF);
		chk("irq", {31'h0, nand_irq}, 32'h0);
		$display("test burst done");
	endtask

	// ----------------------------------------------------------------
	// Clock, reset and sequence
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		close_out();
	end

	initial begin
		{srst, psel, penable, pwrite} = 4'h8;
		paddr = 14'h0000;
		pwdata = 32'h0;
		{recv_fifo_full, xmit_fifo_full} = 2'h0;
		{recv_fifo_empty, xmit_fifo_empty} = 2'h3;
		{recv_fifo_level, xmit_fifo_space} = 26'h0;
		{recv_half_level, xmit_half_level} = {13'h0008, 13'h0008};
		{recv_byte_ptr, xmit_byte_ptr} = 4'h0;
		{nand_recv_push, bus_recv_pop, bus_xmit_push} = 3'h0;
		nand_recv_push_size = `NFI_SIZE_WORD;
		bus_recv_pop_size = `NFI_SIZE_WORD;
		bus_xmit_push_size = `NFI_SIZE_WORD;
		fail_count = 0;
		total_checks = 0;
		repeat (6) @(negedge ref_clk);
		srst = 1'b0;
		test_reset();
		test_edges();
		test_levels();
		test_errors();
		test_mask();
		test_burst();
		close_out();
	end
endmodule
`default_nettype wire
